// file: hdl/tcm_pkg.sv
/*
  Package of the tandem connection monitor: register map, reset values,
  overhead byte positions, multiframe layout and the carrier structs.
  Assumes the frame stream is bit serial, bit 1 of each byte first.
*/
package tcm_pkg;
  // ----------------------------------------------------------------
  // frame and multiframe layout
  // ----------------------------------------------------------------
  localparam logic [11:0] EM_POS = 12'h001;
  localparam logic [11:0] NR_POS = 12'h002;
  localparam logic [6:0] MF_LEN = 7'h4C;
  localparam logic [6:0] FAS_LAST = 7'h05;
  localparam logic [11:0] FAS_PAT = 12'hFFE;
  localparam logic [6:0] TTI_FIRST = 7'h08;
  localparam logic [6:0] TTI_LAST = 7'h47;
  localparam logic [6:0] RDI_IDX = 7'h48;
  localparam logic [6:0] ODI_IDX = 7'h49;
  localparam logic [2:0] UNEQ_N = 3'h5;
  localparam logic [2:0] PERSIST_N = 3'h5;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_DEG = 8'h04;
  localparam logic [7:0] REG_STAT = 8'h08;
  localparam logic [7:0] REG_EXTI = 8'h10;
  localparam logic [7:0] REG_ACTI = 8'h20;
  localparam logic [7:0] REG_PN_EBC = 8'h30;
  localparam logic [7:0] REG_PF_EBC = 8'h34;
  localparam logic [7:0] REG_POF_EBC = 8'h38;
  localparam logic [7:0] REG_PDS = 8'h3C;
  localparam logic [4:0] CTRL_RST = 5'h00;
  localparam logic [15:0] DEGTHR_RST = 16'h0010;
  localparam logic [3:0] DEGM_RST = 4'h3;
  localparam int DEGM_POS = 16;
  // ----------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic d;
    logic ck;
    logic fs;
    logic ssf;
  } tcm_link_s;
  typedef struct packed {
    logic timdis;
    logic odi_rep;
    logic rdi_rep;
    logic ssf_rep;
    logic mon;
  } tcm_ctrl_s;
  typedef struct packed {
    logic uneq;
    logic ltc;
    logic tim;
    logic deg;
    logic ssf;
    logic rdi;
    logic odi;
  } tcm_faults_s;
endpackage

// file: hdl/tcm_mfa.sv
/*
  Multiframe alignment on bits 7 and 8 of the overhead byte.
  Assumes one frame event pulse per frame, beside that frame's two bits.
*/
`timescale 1ns/1ps
module tcm_mfa
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input wire logic frame_ev_i,
  input wire logic [1:0] bits_i,
  output logic in_mf_o,
  output logic [6:0] idx_o
);
  logic [11:0] sh_r;
  logic [11:0] sh_nxt;
  logic [6:0] idx_r;
  logic [6:0] idx_nxt;
  logic in_mf_r;
  logic in_mf_nxt;
  logic err_r;
  logic err_nxt;

  always_comb
  begin
    sh_nxt = sh_r;
    idx_nxt = idx_r;
    in_mf_nxt = in_mf_r;
    err_nxt = err_r;
    if (frame_ev_i)
    begin
      sh_nxt = {sh_r[9:0], bits_i};
      idx_nxt = (idx_r == tcm_pkg::MF_LEN - 7'h01) ? 7'h00 : idx_r + 7'h01;
      if (in_mf_r && idx_nxt == tcm_pkg::FAS_LAST)
      begin
        err_nxt = (sh_nxt != tcm_pkg::FAS_PAT);
        if (err_r && err_nxt)
          in_mf_nxt = 1'b0;
      end
      else if (!in_mf_r && sh_nxt == tcm_pkg::FAS_PAT)
      begin
        in_mf_nxt = 1'b1;
        idx_nxt = tcm_pkg::FAS_LAST;
        err_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      sh_r <= 12'h000;
      idx_r <= 7'h00;
      in_mf_r <= 1'b0;
      err_r <= 1'b0;
    end
    else
    begin
      sh_r <= sh_nxt;
      idx_r <= idx_nxt;
      in_mf_r <= in_mf_nxt;
      err_r <= err_nxt;
    end
  end

  assign in_mf_o = in_mf_r;
  assign idx_o = idx_r;
endmodule

// file: hdl/tcm_monitor.sv
/*
  Non-intrusive tandem connection monitor sink for a serial frame stream.
  Assumes link signals are asynchronous pins, one_sec_i and eq_defect_i
  come from logic on clk_i, and the bus strobes are one cycle long.
*/
// Local design decisions: the strobed register port and the register addresses.
`timescale 1ns/1ps
module tcm_monitor
(
  input wire logic clk_i,
  input wire logic resetn_i,
  input tcm_pkg::tcm_link_s ci_i,
  input wire logic eq_defect_i,
  input wire logic one_sec_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  output tcm_pkg::tcm_link_s ci_o,
  output logic tsf_o,
  output logic tsd_o,
  output tcm_pkg::tcm_faults_s faults_o
);
  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  tcm_pkg::tcm_link_s s1_r;
  tcm_pkg::tcm_link_s s2_r;
  logic ck_d_r;
  logic ck_rise;

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      s1_r <= '0;
      s2_r <= '0;
      ck_d_r <= 1'b0;
    end
    else
    begin
      s1_r <= ci_i;
      s2_r <= s1_r;
      ck_d_r <= s2_r.ck;
    end
  end
  assign ck_rise = s2_r.ck && !ck_d_r;
  assign ci_o = s2_r;

  // ----------------------------------------------------------------
  // framing and overhead capture
  // ----------------------------------------------------------------
  logic [2:0] bitc_r, bitc_nxt;
  logic [11:0] bytec_r, bytec_nxt;
  logic [6:0] sh_r, sh_nxt;
  logic [7:0] par_r, par_nxt, prev_par_r, prev_par_nxt;
  logic [7:0] em_r, em_nxt, nr_r, nr_nxt;
  logic [1:0] seen_r, seen_nxt;
  logic nr_ev_r, nr_ev_nxt;
  logic [7:0] byte_v;

  always_comb
  begin
    bitc_nxt = bitc_r;
    bytec_nxt = bytec_r;
    sh_nxt = sh_r;
    par_nxt = par_r;
    prev_par_nxt = prev_par_r;
    em_nxt = em_r;
    nr_nxt = nr_r;
    seen_nxt = seen_r;
    nr_ev_nxt = 1'b0;
    byte_v = {sh_r, s2_r.d};
    if (ck_rise)
    begin
      sh_nxt = byte_v[6:0];
      if (s2_r.fs)
      begin
        bitc_nxt = 3'h1;
        bytec_nxt = 12'h000;
        // parity of the whole preceding frame
        prev_par_nxt = par_r;
        par_nxt = 8'h00;
        seen_nxt = {seen_r[0], 1'b1};
      end
      else
      begin
        bitc_nxt = bitc_r + 3'h1;
        if (bitc_nxt == 3'h0)
        begin
          bytec_nxt = bytec_r + 12'h001;
          par_nxt = par_r ^ byte_v;
          if (bytec_r == tcm_pkg::EM_POS)
            em_nxt = byte_v;
          // no processing until a whole previous frame was seen
          if (bytec_r == tcm_pkg::NR_POS && seen_r[1])
          begin
            nr_nxt = byte_v;
            nr_ev_nxt = 1'b1;
          end
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      bitc_r <= 3'h0;
      bytec_r <= 12'h000;
      sh_r <= 7'h00;
      par_r <= 8'h00;
      prev_par_r <= 8'h00;
      em_r <= 8'h00;
      nr_r <= 8'h00;
      seen_r <= 2'h0;
      nr_ev_r <= 1'b0;
    end
    else
    begin
      bitc_r <= bitc_nxt;
      bytec_r <= bytec_nxt;
      sh_r <= sh_nxt;
      par_r <= par_nxt;
      prev_par_r <= prev_par_nxt;
      em_r <= em_nxt;
      nr_r <= nr_nxt;
      seen_r <= seen_nxt;
      nr_ev_r <= nr_ev_nxt;
    end
  end

  // ----------------------------------------------------------------
  // per-frame checks
  // ----------------------------------------------------------------
  logic [3:0] non, iec, diff;
  logic nn_b_r, nn_b_nxt, nf_b_r, nf_b_nxt, nof_b_r, nof_b_nxt;
  logic [2:0] uneq_cnt_r, uneq_cnt_nxt;
  logic d_uneq_r, d_uneq_nxt;
  logic mf_ev_r;
  logic in_mf;
  logic [6:0] mf_idx;

  always_comb
  begin
    non = 4'h0;
    for (int i = 0; i < 8; i++)
      non = non + {3'h0, prev_par_r[i] ^ em_r[i]};
    iec = nr_r[7:4];
    diff = (non > iec) ? non - iec : iec - non;
    nn_b_nxt = 1'b0;
    nf_b_nxt = 1'b0;
    nof_b_nxt = 1'b0;
    uneq_cnt_nxt = uneq_cnt_r;
    d_uneq_nxt = d_uneq_r;
    if (nr_ev_r)
    begin
      nn_b_nxt = (diff >= 4'h1);
      nf_b_nxt = nr_r[3];
      nof_b_nxt = nr_r[2];
      if ((nr_r == 8'h00) != d_uneq_r)
      begin
        uneq_cnt_nxt = uneq_cnt_r + 3'h1;
        if (uneq_cnt_nxt == tcm_pkg::UNEQ_N)
        begin
          d_uneq_nxt = !d_uneq_r;
          uneq_cnt_nxt = 3'h0;
        end
      end
      else
        uneq_cnt_nxt = 3'h0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      nn_b_r <= 1'b0;
      nf_b_r <= 1'b0;
      nof_b_r <= 1'b0;
      uneq_cnt_r <= 3'h0;
      d_uneq_r <= 1'b0;
      mf_ev_r <= 1'b0;
    end
    else
    begin
      nn_b_r <= nn_b_nxt;
      nf_b_r <= nf_b_nxt;
      nof_b_r <= nof_b_nxt;
      uneq_cnt_r <= uneq_cnt_nxt;
      d_uneq_r <= d_uneq_nxt;
      mf_ev_r <= nr_ev_r;
    end
  end

  tcm_mfa u_mfa
  (
    .clk_i(clk_i),
    .resetn_i(resetn_i),
    .frame_ev_i(nr_ev_r),
    .bits_i(nr_r[1:0]),
    .in_mf_o(in_mf),
    .idx_o(mf_idx)
  );

  // ----------------------------------------------------------------
  // trace, remote and outgoing indications
  // ----------------------------------------------------------------
  logic [127:0] rx_r, rx_nxt, last_r, last_nxt, acti_r, acti_nxt, exti_r;
  logic tim_raw_r, tim_raw_nxt;
  logic [1:0] d_rx;
  tcm_pkg::tcm_ctrl_s ctrl_r;
  logic d_ltc, d_tim;

  always_comb
  begin
    rx_nxt = rx_r;
    last_nxt = last_r;
    acti_nxt = acti_r;
    tim_raw_nxt = tim_raw_r;
    // trace bits collected only while aligned
    if (mf_ev_r && in_mf && mf_idx >= tcm_pkg::TTI_FIRST && mf_idx <= tcm_pkg::TTI_LAST)
    begin
      rx_nxt = {rx_r[125:0], nr_r[1:0]};
      if (mf_idx == tcm_pkg::TTI_LAST)
      begin
        last_nxt = rx_nxt;
        // two equal traces in a row before acceptance, against bit errors
        if (rx_nxt == last_r)
          acti_nxt = rx_nxt;
        // refreshed once per multiframe, well under a second
        tim_raw_nxt = (acti_nxt != exti_r);
      end
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      rx_r <= '0;
      last_r <= '0;
      acti_r <= '0;
      tim_raw_r <= 1'b0;
    end
    else
    begin
      rx_r <= rx_nxt;
      last_r <= last_nxt;
      acti_r <= acti_nxt;
      tim_raw_r <= tim_raw_nxt;
    end
  end

  assign d_ltc = !in_mf;
  // held off on server fail or by control
  assign d_tim = tim_raw_r && !ctrl_r.timdis && !s2_r.ssf;

  // index 0 is RDI (bit 8), index 1 is ODI (bit 7)
  for (genvar k = 0; k < 2; k++)
  begin : g_ind
    logic [2:0] cnt_r, cnt_nxt;
    logic d_r, d_nxt, smp;
    always_comb
    begin
      cnt_nxt = cnt_r;
      d_nxt = d_r;
      smp = nr_r[k];
      // one per multiframe, five in a row flips the defect
      if (mf_ev_r && in_mf && mf_idx == (k == 0 ? tcm_pkg::RDI_IDX : tcm_pkg::ODI_IDX))
      begin
        if (smp != d_r)
        begin
          cnt_nxt = cnt_r + 3'h1;
          if (cnt_nxt == tcm_pkg::PERSIST_N)
          begin
            d_nxt = smp;
            cnt_nxt = 3'h0;
          end
        end
        else
          cnt_nxt = 3'h0;
      end
    end
    always_ff @(posedge clk_i or negedge resetn_i)
    begin
      if (!resetn_i)
      begin
        cnt_r <= 3'h0;
        d_r <= 1'b0;
      end
      else
      begin
        cnt_r <= cnt_nxt;
        d_r <= d_nxt;
      end
    end
    assign d_rx[k] = d_r;
  end

  // ----------------------------------------------------------------
  // degrade and one-second counts
  // ----------------------------------------------------------------
  logic [19:0] nn_acc_r, nn_acc_nxt, nf_acc_r, nf_acc_nxt, nof_acc_r, nof_acc_nxt;
  logic [19:0] pn_r, pn_nxt, pf_r, pf_nxt, pof_r, pof_nxt;
  logic [2:0] ds_acc_r, ds_acc_nxt, pds_r, pds_nxt, ds_now;
  logic [3:0] deg_cnt_r, deg_cnt_nxt;
  logic d_deg_r, d_deg_nxt, bad;
  logic [15:0] degthr_r;
  logic [3:0] degm_r;

  always_comb
  begin
    // near-end, far-end and outgoing far-end defect seconds
    ds_now = {d_rx[1], d_rx[0], tsf_o || eq_defect_i};
    nn_acc_nxt = nn_acc_r + {19'h0, nn_b_r};
    nf_acc_nxt = nf_acc_r + {19'h0, nf_b_r};
    nof_acc_nxt = nof_acc_r + {19'h0, nof_b_r};
    ds_acc_nxt = ds_acc_r | ds_now;
    pn_nxt = pn_r;
    pf_nxt = pf_r;
    pof_nxt = pof_r;
    pds_nxt = pds_r;
    deg_cnt_nxt = deg_cnt_r;
    d_deg_nxt = d_deg_r;
    bad = (nn_acc_nxt >= {4'h0, degthr_r});
    // latch and restart on the tick
    if (one_sec_i)
    begin
      pn_nxt = nn_acc_nxt;
      pf_nxt = nf_acc_nxt;
      pof_nxt = nof_acc_nxt;
      pds_nxt = ds_acc_nxt;
      nn_acc_nxt = 20'h0;
      nf_acc_nxt = 20'h0;
      nof_acc_nxt = 20'h0;
      ds_acc_nxt = 3'h0;
      // run of degm bad or good seconds flips the defect
      if (bad != d_deg_r)
      begin
        deg_cnt_nxt = deg_cnt_r + 4'h1;
        if (deg_cnt_nxt >= degm_r)
        begin
          d_deg_nxt = bad;
          deg_cnt_nxt = 4'h0;
        end
      end
      else
        deg_cnt_nxt = 4'h0;
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      nn_acc_r <= 20'h0;
      nf_acc_r <= 20'h0;
      nof_acc_r <= 20'h0;
      ds_acc_r <= 3'h0;
      pn_r <= 20'h0;
      pf_r <= 20'h0;
      pof_r <= 20'h0;
      pds_r <= 3'h0;
      deg_cnt_r <= 4'h0;
      d_deg_r <= 1'b0;
    end
    else
    begin
      nn_acc_r <= nn_acc_nxt;
      nf_acc_r <= nf_acc_nxt;
      nof_acc_r <= nof_acc_nxt;
      ds_acc_r <= ds_acc_nxt;
      pn_r <= pn_nxt;
      pf_r <= pf_nxt;
      pof_r <= pof_nxt;
      pds_r <= pds_nxt;
      deg_cnt_r <= deg_cnt_nxt;
      d_deg_r <= d_deg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // consequent actions and fault causes
  // ----------------------------------------------------------------
  tcm_pkg::tcm_faults_s cf_nxt;
  logic tsf_nxt, clean;

  always_comb
  begin
    tsf_nxt = s2_r.ssf || d_uneq_r || d_tim || d_ltc;
    clean = !d_uneq_r && !d_tim && !d_ltc;
    cf_nxt.uneq = ctrl_r.mon && d_uneq_r;
    cf_nxt.ltc = ctrl_r.mon && !d_uneq_r && d_ltc;
    cf_nxt.tim = ctrl_r.mon && !d_uneq_r && !d_ltc && d_tim;
    cf_nxt.deg = ctrl_r.mon && !d_tim && !d_ltc && d_deg_r;
    cf_nxt.ssf = ctrl_r.mon && s2_r.ssf && ctrl_r.ssf_rep;
    cf_nxt.rdi = ctrl_r.mon && clean && d_rx[0] && ctrl_r.rdi_rep;
    cf_nxt.odi = ctrl_r.mon && clean && d_rx[1] && ctrl_r.odi_rep;
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      faults_o <= '0;
      tsf_o <= 1'b0;
      tsd_o <= 1'b0;
    end
    else
    begin
      faults_o <= cf_nxt;
      tsf_o <= tsf_nxt;
      tsd_o <= d_deg_r;
    end
  end

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  tcm_pkg::tcm_ctrl_s ctrl_nxt;
  logic [15:0] degthr_nxt;
  logic [3:0] degm_nxt;
  logic [127:0] exti_nxt;
  logic [31:0] rdata_nxt;

  always_comb
  begin
    ctrl_nxt = ctrl_r;
    degthr_nxt = degthr_r;
    degm_nxt = degm_r;
    exti_nxt = exti_r;
    rdata_nxt = 32'h0;
    if (wr_i && addr_i == tcm_pkg::REG_CTRL)
      ctrl_nxt = wdata_i[4:0];
    if (wr_i && addr_i == tcm_pkg::REG_DEG)
    begin
      degthr_nxt = wdata_i[15:0];
      degm_nxt = wdata_i[tcm_pkg::DEGM_POS +: 4];
    end
    for (int w = 0; w < 4; w++)
    begin
      if (wr_i && addr_i == tcm_pkg::REG_EXTI + 8'(4 * w))
        exti_nxt[32 * (3 - w) +: 32] = wdata_i;
      if (rd_i && addr_i == tcm_pkg::REG_EXTI + 8'(4 * w))
        rdata_nxt = exti_r[32 * (3 - w) +: 32];
      if (rd_i && addr_i == tcm_pkg::REG_ACTI + 8'(4 * w))
        rdata_nxt = acti_r[32 * (3 - w) +: 32];
    end
    if (rd_i)
    begin
      case (addr_i)
        tcm_pkg::REG_CTRL: rdata_nxt = {27'h0, ctrl_r};
        tcm_pkg::REG_DEG: rdata_nxt = {12'h0, degm_r, degthr_r};
        tcm_pkg::REG_STAT: rdata_nxt = {25'h0, d_rx, d_deg_r, d_tim, d_ltc, d_uneq_r, in_mf};
        tcm_pkg::REG_PN_EBC: rdata_nxt = {12'h0, pn_r};
        tcm_pkg::REG_PF_EBC: rdata_nxt = {12'h0, pf_r};
        tcm_pkg::REG_POF_EBC: rdata_nxt = {12'h0, pof_r};
        tcm_pkg::REG_PDS: rdata_nxt = {29'h0, pds_r};
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
    begin
      ctrl_r <= tcm_pkg::CTRL_RST;
      degthr_r <= tcm_pkg::DEGTHR_RST;
      degm_r <= tcm_pkg::DEGM_RST;
      exti_r <= '0;
      rdata_o <= 32'h0;
    end
    else
    begin
      ctrl_r <= ctrl_nxt;
      degthr_r <= degthr_nxt;
      degm_r <= degm_nxt;
      exti_r <= exti_nxt;
      rdata_o <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!resetn_i);

  nn_block_a: assert property (nr_ev_r && diff != 4'h0 |=> nn_b_r)
    else $error("errored block not flagged");
  rei_bit_a: assert property (nr_ev_r |=> nf_b_r == $past(nr_r[3]))
    else $error("far-end error bit wrong");
  uneq_rise_a: assert property ($rose(d_uneq_r) |-> $past(nr_r) == 8'h00)
    else $error("unequipped raised on nonzero byte");
  ltc_state_a: assert property (!in_mf |=> tsf_o)
    else $error("trail fail missing on loss of alignment");
  tim_ssf_a: assert property (s2_r.ssf |=> !faults_o.tim)
    else $error("mismatch cause during server fail");
  tsf_or_a: assert property (d_uneq_r && $stable(d_uneq_r) |=> tsf_o)
    else $error("trail fail missing");
  tim_mask_a: assert property (faults_o.tim |->
    !$past(d_uneq_r) && !$past(d_ltc) && $past(ctrl_r.mon))
    else $error("mismatch cause not masked");
  rdi_rep_a: assert property (faults_o.rdi |-> $past(ctrl_r.rdi_rep) && $past(d_rx[0]))
    else $error("remote cause without enable");
  sec_latch_a: assert property (one_sec_i |=> pds_r == ($past(ds_acc_r) | $past(ds_now)))
    else $error("defect seconds not latched");
  stream_pass_a: assert property (##2 ci_o == $past(ci_i, 2))
    else $error("stream altered");

  align_c: cover property ($rose(in_mf));
  uneq_c: cover property ($rose(d_uneq_r));
  tim_c: cover property ($rose(d_tim));
  sec_c: cover property (one_sec_i && pn_r != 20'h0);
endmodule

// file: verif/tcm_src_model.sv
/*
  Far-end source model: sends three-byte frames with EM parity and the NR
  overhead byte, multiframe bits 7-8 included.
  Assumes the bench changes its controls early in each frame.
*/
`timescale 1ns/1ps
module tcm_src_model
(
  input wire logic en_i,
  input wire logic [7:0] em_flip_i,
  input wire logic [3:0] iec_i,
  input wire logic rei_i,
  input wire logic oei_i,
  input wire logic uneq_i,
  output tcm_pkg::tcm_link_s link_o,
  output logic [15:0] frames_o
);
  logic [7:0] by [3];
  logic [7:0] par;
  logic [6:0] mf;
  logic [1:0] b78;
  initial
  begin
    link_o = '0;
    frames_o = '0;
    par = 8'h00;
    mf = '0;
    wait (en_i);
    // offset keeps link edges away from rising clock edges, on the falling ones
    #2;
    forever
    begin
      by[0] = 8'hA5;
      for (int b = 0; b < 3; b++)
      begin
        if (b == 1)
        begin
          b78 = 2'b10;
          if (mf <= tcm_pkg::FAS_LAST)
            b78 = tcm_pkg::FAS_PAT[11 - 2 * mf -: 2];
          else if (mf == tcm_pkg::ODI_IDX)
            b78 = 2'b01;
          by[1] = par ^ em_flip_i;
          by[2] = uneq_i ? 8'h00 : {iec_i, rei_i, oei_i, b78};
        end
        for (int i = 7; i >= 0; i--)
        begin
          link_o.ck = 1'b0;
          link_o.d = by[b][i];
          link_o.fs = (b == 0) && (i == 7);
          #40;
          link_o.ck = 1'b1;
          #40;
        end
      end
      par = by[0] ^ by[1] ^ by[2];
      mf = (mf == tcm_pkg::MF_LEN - 7'h01) ? 7'h00 : mf + 7'h01;
      frames_o = frames_o + 16'h0001;
    end
  end
endmodule

// file: verif/tcm_monitor_tb.sv
/*
  Self-checking bench of the tandem connection monitor, one task a scenario.
  Assumes the package, the design and the source model are compiled first.
*/
`timescale 1ns/1ps
module tcm_monitor_tb;
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic ssf = 1'b0;
  logic eq_def = 1'b0;
  logic one_sec = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic en = 1'b0;
  logic [7:0] em_flip = 8'h00;
  logic [3:0] iec = 4'h0;
  logic rei = 1'b0;
  logic oei = 1'b0;
  logic uneq = 1'b0;
  logic [31:0] rdata;
  logic [15:0] frames;
  logic tsf;
  logic tsd;
  tcm_pkg::tcm_link_s link;
  tcm_pkg::tcm_link_s ci;
  tcm_pkg::tcm_link_s ci_out;
  tcm_pkg::tcm_faults_s faults;
  int errors = 0;
  int checks_done = 0;
  always #2 clk_i = ~clk_i;
  assign ci = '{d: link.d, ck: link.ck, fs: link.fs, ssf: ssf};
  tcm_src_model u_tcm_src_model (.en_i(en), .em_flip_i(em_flip), .iec_i(iec), .rei_i(rei),
    .oei_i(oei), .uneq_i(uneq), .link_o(link), .frames_o(frames));
  tcm_monitor u_tcm_monitor (.clk_i(clk_i), .resetn_i(resetn_i), .ci_i(ci),
    .eq_defect_i(eq_def), .one_sec_i(one_sec), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
    .rd_i(rd), .rdata_o(rdata), .ci_o(ci_out), .tsf_o(tsf), .tsd_o(tsd), .faults_o(faults));
  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    #1 d = rdata;
    @(posedge clk_i);
  endtask
  task automatic wait_fr(input int n);
    wait (frames >= n);
    repeat (20) @(posedge clk_i);
  endtask
  task automatic tick();
    one_sec <= 1'b1;
    @(posedge clk_i);
    one_sec <= 1'b0;
    @(posedge clk_i);
  endtask
  // {faults, tsf, tsd} as one word
  function automatic logic [31:0] outs();
    return {23'h0, faults, tsf, tsd};
  endfunction
  task automatic final_report();
    if (errors == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset();
    logic [31:0] v;
    tcm_pkg::tcm_link_s s;
    repeat (4) @(posedge clk_i);
    chk(outs(), 32'h0);
    resetn_i <= 1'b1;
    en <= 1'b1;
    repeat (10) @(posedge clk_i);
    #1 chk(outs(), 32'h2);
    rd_reg(tcm_pkg::REG_CTRL, v);
    chk(v, {27'h0, tcm_pkg::CTRL_RST});
    rd_reg(8'h44, v);
    chk(v, 32'h0);
    for (int k = 0; k < 40; k++)
    begin
      #1 s = ci;
      repeat (2) @(posedge clk_i);
      #1 chk({28'h0, ci_out}, {28'h0, s});
      repeat (3) @(posedge clk_i);
    end
  endtask
  task automatic t_align();
    logic [31:0] v;
    for (int k = 0; k < 4; k++)
      wr_reg(tcm_pkg::REG_EXTI + 8'(4 * k), 32'hAAAAAAAA);
    wr_reg(tcm_pkg::REG_CTRL, 32'h1);
    wait_fr(84);
    rd_reg(tcm_pkg::REG_STAT, v);
    chk(v & 32'h0F, 32'h1);
    chk(outs(), 32'h0);
  endtask
  task automatic t_ssf();
    wr_reg(tcm_pkg::REG_CTRL, 32'h3);
    ssf <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(outs(), 32'h12);
    wr_reg(tcm_pkg::REG_CTRL, 32'h1);
    repeat (4) @(posedge clk_i);
    chk(outs(), 32'h2);
    wr_reg(tcm_pkg::REG_CTRL, 32'h2);
    repeat (4) @(posedge clk_i);
    chk(outs(), 32'h2);
    ssf <= 1'b0;
    wr_reg(tcm_pkg::REG_CTRL, 32'h1);
    repeat (10) @(posedge clk_i);
    chk(outs(), 32'h0);
  endtask
  task automatic t_uneq();
    int f;
    f = frames;
    uneq <= 1'b1;
    wait_fr(f + 4);
    chk(outs(), 32'h0);
    wait_fr(f + 5);
    uneq <= 1'b0;
    chk(outs(), 32'h102);
    wait_fr(f + 9);
    chk(outs(), 32'h102);
    wait_fr(f + 10);
    chk(outs(), 32'h0);
  endtask
  task automatic t_errs();
    logic [31:0] v;
    int f;
    f = frames;
    tick();
    // threshold 2 blocks, one second to set or clear
    wr_reg(tcm_pkg::REG_DEG, 32'h00010002);
    iec <= 4'h3;
    rei <= 1'b1;
    wait_fr(f + 1);
    em_flip <= 8'h01;
    iec <= 4'h1;
    wait_fr(f + 2);
    em_flip <= 8'h03;
    iec <= 4'h0;
    rei <= 1'b0;
    oei <= 1'b1;
    wait_fr(f + 3);
    em_flip <= 8'h00;
    oei <= 1'b0;
    wait_fr(f + 4);
    tick();
    rd_reg(tcm_pkg::REG_PN_EBC, v);
    chk(v, 32'h2);
    rd_reg(tcm_pkg::REG_PF_EBC, v);
    chk(v, 32'h2);
    rd_reg(tcm_pkg::REG_POF_EBC, v);
    chk(v, 32'h1);
    rd_reg(tcm_pkg::REG_PDS, v);
    chk(v, 32'h0);
    chk(outs(), 32'h21);
    eq_def <= 1'b1;
    repeat (5) @(posedge clk_i);
    eq_def <= 1'b0;
    tick();
    rd_reg(tcm_pkg::REG_PDS, v);
    chk(v, 32'h1);
    chk(outs(), 32'h0);
  endtask
  task automatic t_tim();
    logic [31:0] v;
    // first trace ends at frame 148: not accepted, unlike the expected one
    wait_fr(150);
    rd_reg(tcm_pkg::REG_STAT, v);
    chk(v & 32'h0F, 32'h9);
    rd_reg(tcm_pkg::REG_ACTI, v);
    chk(v, 32'h0);
    chk(outs(), 32'h42);
    ssf <= 1'b1;
    repeat (10) @(posedge clk_i);
    chk(outs(), 32'h2);
    ssf <= 1'b0;
    wr_reg(tcm_pkg::REG_CTRL, 32'h11);
    repeat (4) @(posedge clk_i);
    chk(outs(), 32'h0);
  endtask
  initial
  begin
    #340000;
    errors++;
    final_report();
  end
  initial
  begin
    t_reset();
    t_align();
    t_ssf();
    t_uneq();
    t_errs();
    t_tim();
    final_report();
  end
endmodule
